// File: inc/dbtu_regs.vh
`ifndef DBTU_REGS_VH
`define DBTU_REGS_VH

// ---------------------------------------------------------------
// vectors and constants
// ---------------------------------------------------------------
`define DBTU_VEC_STEP        8'h01
`define DBTU_VEC_BREAK       8'h03
`define DBTU_SWINT_BREAK_NUM 8'h03
`define DBTU_TRACE_BIT       8
`define DBTU_RESET_FETCH     32'hFFFF_FFF0
`define DBTU_NUM_BP          4

// ---------------------------------------------------------------
// control register layout
// ---------------------------------------------------------------
`define DBTU_CTL_L(i)        (2*(i))
`define DBTU_CTL_G(i)        (2*(i)+1)
`define DBTU_CTL_LE          8
`define DBTU_CTL_GE          9
`define DBTU_CTL_RW(i)       (16+4*(i))
`define DBTU_CTL_LEN(i)      (18+4*(i))
`define DBTU_CTL_RESET       32'h0000_0000

// ---------------------------------------------------------------
// access type and length encodings
// ---------------------------------------------------------------
`define DBTU_RW_EXEC         2'h0
`define DBTU_RW_WRITE        2'h1
`define DBTU_RW_RDWR         2'h3
`define DBTU_LEN_1           2'h0
`define DBTU_LEN_2           2'h1
`define DBTU_LEN_4           2'h3

// ---------------------------------------------------------------
// cause register layout
// ---------------------------------------------------------------
`define DBTU_CAUSE_STEP      14
`define DBTU_CAUSE_RESET     32'h0000_0000

`endif

// File: src/dbtu_bp_match.v
`timescale 1ns/100ps

// ---------------------------------------------------------------
// one address breakpoint comparator
// ---------------------------------------------------------------
module dbtu_bp_match
(
  input  wire [31:0] bp_addr_in,
  input  wire [1:0]  bp_rw_in,
  input  wire [1:0]  bp_len_in,
  input  wire        bp_en_in,
  input  wire [31:0] lin_addr_in,
  input  wire        fetch_in,
  input  wire        data_rd_in,
  input  wire        data_wr_in,
  output wire        hit_out
);

  `include "dbtu_regs.vh"

  reg  [1:0] low_mask;
  wire       addr_eq;
  reg        type_ok;

  // length masks low address bits
  always @*
  begin
    case (bp_len_in)
      `DBTU_LEN_2: low_mask = 2'h1;
      `DBTU_LEN_4: low_mask = 2'h3;
      default:     low_mask = 2'h0;
    endcase
  end

  // linear address, pre-paging
  assign addr_eq = (bp_addr_in[31:2] == lin_addr_in[31:2]) &&
                   ((bp_addr_in[1:0] & ~low_mask) ==
                    (lin_addr_in[1:0] & ~low_mask)); // RULE8 RULE12

  always @*
  begin
    case (bp_rw_in)
      `DBTU_RW_EXEC:  type_ok = fetch_in;
      `DBTU_RW_WRITE: type_ok = data_wr_in;
      `DBTU_RW_RDWR:  type_ok = data_rd_in | data_wr_in;
      default:        type_ok = 1'b0; // RULE11
    endcase
  end

  assign hit_out = bp_en_in & type_ok & addr_eq; // RULE7 RULE11

endmodule // dbtu_bp_match

// File: src/dbtu_trap_unit.v
// Notes on behaviour
// RULE1 - the one-byte break opcode traps to vector 3 like software int 3.
// RULE2 - int n is privilege checked in protected and v86 mode, break never.
// RULE3 - flags bit 8 set: vector 1 step trap after the next instruction.
// RULE4 - the step trap returns to the next unexecuted instruction.
// RULE5 - the step trap due right after a stack segment load is held off.
// RULE6 - six debug registers: four addresses, one cause and one control.
// RULE7 - each 32-bit address is compared with every fetch and data address.
// RULE8 - comparisons use linear addresses regardless of paging.
// RULE9 - reset disables all four breakpoints.
// RULE10 - after reset, fetch starts at FFFFFFF0H.
// RULE11 - type 00 execute, 01 write, 11 read or write, 10 never matches.
// RULE12 - length field selects 1, 2 or 4 bytes by masking low address bits.
// RULE13 - an enabled breakpoint hit, global or local, raises vector 1.
// RULE14 - a task switch clears local exact enable and keeps the global one.
// RULE15 - every vector 1 cause sets its own flag in the cause register.
`timescale 1ns/100ps

module dbtu_trap_unit
(
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        instr_done_in,
  input  wire [31:0] next_ip_in,
  input  wire        op_break_in,
  input  wire        op_swint_in,
  input  wire [7:0]  swint_num_in,
  input  wire        prot_mode_in,
  input  wire        v86_mode_in,
  input  wire [1:0]  cpl_in,
  input  wire [1:0]  io_privilege_level_in,
  input  wire [31:0] processor_flags_word_in,
  input  wire        ss_load_in,
  input  wire        task_switch_in,
  input  wire [31:0] lin_addr_in,
  input  wire        fetch_in,
  input  wire        data_rd_in,
  input  wire        data_wr_in,
  input  wire [1:0]  reg_sel_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        bp_addr_wr_in,
  input  wire        ctl_wr_in,
  input  wire        cause_wr_in,
  output reg  [31:0] bp_addr_rd_out,
  output wire [31:0] debug_control_reg_out,
  output wire [31:0] debug_cause_reg_out,
  output reg         exc_req_out,
  output reg  [7:0]  exc_vec_out,
  output reg         exc_fault_out,
  output reg  [31:0] return_code_pointer_out,
  output reg         gp_fault_out,
  output wire [31:0] fetch_start_out
);

  `include "dbtu_regs.vh"

  // ---------------------------------------------------------------
  // debug registers
  // ---------------------------------------------------------------
  reg  [31:0] bp_addr_q [0:`DBTU_NUM_BP-1]; // RULE6
  reg  [31:0] ctl_q;
  reg  [31:0] cause_q;
  reg  [31:0] ctl_d;
  reg  [31:0] cause_d;
  wire [3:0]  hit;
  wire [3:0]  exec_hit;
  wire [3:0]  data_hit;
  reg  [3:0]  data_pend_q;
  wire        step_due;
  wire        break_trap;
  wire        swint_priv_fail;
  integer     k;
  integer     j;

  function bp_active;
    input [31:0] ctl;
    input integer idx;
    begin
      bp_active = ctl[2*idx] | ctl[2*idx+1]; // RULE13
    end
  endfunction

  assign debug_control_reg_out = ctl_q;
  assign debug_cause_reg_out   = cause_q;
  assign fetch_start_out       = `DBTU_RESET_FETCH; // RULE10

  always @*
  begin
    bp_addr_rd_out = bp_addr_q[reg_sel_in];
  end

  // ---------------------------------------------------------------
  // comparators
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `DBTU_NUM_BP; gi = gi + 1)
    begin : g_bp
      dbtu_bp_match u_match
      (
        .bp_addr_in  (bp_addr_q[gi]),
        .bp_rw_in    (ctl_q[`DBTU_CTL_RW(gi)+1:`DBTU_CTL_RW(gi)]),
        .bp_len_in   (ctl_q[`DBTU_CTL_LEN(gi)+1:`DBTU_CTL_LEN(gi)]),
        .bp_en_in    (bp_active(ctl_q, gi)),
        .lin_addr_in (lin_addr_in),
        .fetch_in    (fetch_in),
        .data_rd_in  (data_rd_in),
        .data_wr_in  (data_wr_in),
        .hit_out     (hit[gi])
      ); // RULE7
      assign exec_hit[gi] = hit[gi] &
        (ctl_q[`DBTU_CTL_RW(gi)+1:`DBTU_CTL_RW(gi)] == `DBTU_RW_EXEC);
      assign data_hit[gi] = hit[gi] & ~exec_hit[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // trap decisions
  // ---------------------------------------------------------------
  // no step trap on the boundary right after a stack segment load;
  // the flag still set traps after the following instruction
  assign step_due = instr_done_in & ~ss_load_in &
    processor_flags_word_in[`DBTU_TRACE_BIT]; // RULE3 RULE5
  // one-byte break never checks privilege
  assign break_trap = instr_done_in & op_break_in; // RULE1 RULE2
  assign swint_priv_fail = instr_done_in & op_swint_in &
    (v86_mode_in ? (io_privilege_level_in != 2'h3) :
     prot_mode_in & (cpl_in > io_privilege_level_in)); // RULE2

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  always @*
  begin
    ctl_d   = ctl_q;
    cause_d = cause_q;
    if (ctl_wr_in)
      ctl_d = reg_wdata_in;
    if (task_switch_in)
      ctl_d[`DBTU_CTL_LE] = 1'b0; // RULE14
    if (cause_wr_in)
      cause_d = reg_wdata_in;
    // hardware set wins over software write
    for (k = 0; k < `DBTU_NUM_BP; k = k + 1)
      if (exec_hit[k] | (instr_done_in & data_pend_q[k]))
        cause_d[k] = 1'b1; // RULE15
    if (step_due)
      cause_d[`DBTU_CAUSE_STEP] = 1'b1; // RULE15
  end

  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      for (j = 0; j < `DBTU_NUM_BP; j = j + 1)
        bp_addr_q[j] <= 32'h0000_0000;
      ctl_q        <= `DBTU_CTL_RESET; // RULE9
      cause_q      <= `DBTU_CAUSE_RESET;
      data_pend_q  <= 4'h0;
      exc_req_out  <= 1'b0;
      exc_vec_out  <= 8'h00;
      exc_fault_out <= 1'b0;
      gp_fault_out <= 1'b0;
      return_code_pointer_out <= 32'h0000_0000;
    end
    else
    begin
      if (bp_addr_wr_in)
        bp_addr_q[reg_sel_in] <= reg_wdata_in;
      ctl_q   <= ctl_d;
      cause_q <= cause_d;
      // data hits report after the instruction completes
      data_pend_q <= instr_done_in ? data_hit : (data_pend_q | data_hit);
      gp_fault_out <= swint_priv_fail;
      exc_req_out  <= 1'b0;
      exc_fault_out <= 1'b0;
      if (|exec_hit)
      begin
        exc_req_out   <= 1'b1;
        exc_vec_out   <= `DBTU_VEC_STEP; // RULE13
        exc_fault_out <= 1'b1;
        return_code_pointer_out <= lin_addr_in;
      end
      else if (step_due | (instr_done_in & |data_pend_q))
      begin
        exc_req_out <= 1'b1;
        exc_vec_out <= `DBTU_VEC_STEP; // RULE3 RULE13
        return_code_pointer_out <= next_ip_in; // RULE4
      end
      else if (break_trap |
               (instr_done_in & op_swint_in & ~swint_priv_fail &
                swint_num_in == `DBTU_SWINT_BREAK_NUM))
      begin
        exc_req_out <= 1'b1;
        exc_vec_out <= `DBTU_VEC_BREAK; // RULE1
        return_code_pointer_out <= next_ip_in; // RULE4
      end
    end
  end

endmodule // dbtu_trap_unit

// File: testbench/dbtu_chk.sv
`timescale 1ns/100ps
module dbtu_chk
(
  input wire        clk_in,
  input wire        nrst_in,
  input wire        instr_done_in,
  input wire [31:0] next_ip_in,
  input wire        op_break_in,
  input wire [31:0] processor_flags_word_in,
  input wire        ss_load_in,
  input wire        task_switch_in,
  input wire        ctl_wr_in,
  input wire [31:0] lin_addr_in,
  input wire        fetch_in,
  input wire [1:0]  reg_sel_in,
  input wire [31:0] bp_addr_rd_out,
  input wire [31:0] debug_control_reg_out,
  input wire [31:0] debug_cause_reg_out,
  input wire        exc_req_out,
  input wire [7:0]  exc_vec_out,
  input wire        exc_fault_out,
  input wire [31:0] return_code_pointer_out,
  input wire        gp_fault_out
);
  wire [31:0] ctl = debug_control_reg_out;
  wire        dn  = instr_done_in;
  wire        tf  = processor_flags_word_in[8];
  wire        off = ctl[7:0] == 8'h00;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  chk_break_vec:
    assert property (dn && op_break_in && !tf && off |=> exc_req_out
      && !exc_fault_out && exc_vec_out == 8'h03) else $error("break trap");
  chk_break_nogp:
    assert property (dn && op_break_in |=> !gp_fault_out)
      else $error("break gp fault");
  chk_step_vec:
    assert property (dn && tf && !ss_load_in && off |=> exc_req_out
      && exc_vec_out == 8'h01 && !exc_fault_out && debug_cause_reg_out[14]
      && return_code_pointer_out == $past(next_ip_in)) else $error("step");
  chk_step_mask:
    assert property (dn && ss_load_in && !op_break_in && off |=> !exc_req_out)
      else $error("step not held off");
  chk_reset_off:
    assert property (disable iff (1'b0) !nrst_in |=> ctl == 32'h0000_0000
      && !exc_req_out) else $error("reset state");
  chk_idle_quiet:
    assert property (!dn && !fetch_in |=> !exc_req_out)
      else $error("request without cause");
  chk_exec_hit:
    assert property (fetch_in && reg_sel_in == 2'h0 && ctl[1:0] != 2'h0
      && ctl[17:16] == 2'h0 && lin_addr_in == bp_addr_rd_out |=> exc_req_out
      && exc_fault_out && exc_vec_out == 8'h01 && debug_cause_reg_out[0]
      && return_code_pointer_out == $past(lin_addr_in)) else $error("exec");
  chk_task_le:
    assert property (task_switch_in && !ctl_wr_in |=> !ctl[8]
      && $stable(ctl[9])) else $error("task switch enables");
endmodule // dbtu_chk

bind dbtu_trap_unit dbtu_chk u_chk
(
  .clk_in                  (clk_in),
  .nrst_in                 (nrst_in),
  .instr_done_in           (instr_done_in),
  .next_ip_in              (next_ip_in),
  .op_break_in             (op_break_in),
  .processor_flags_word_in (processor_flags_word_in),
  .ss_load_in              (ss_load_in),
  .task_switch_in          (task_switch_in),
  .ctl_wr_in               (ctl_wr_in),
  .lin_addr_in             (lin_addr_in),
  .fetch_in                (fetch_in),
  .reg_sel_in              (reg_sel_in),
  .bp_addr_rd_out          (bp_addr_rd_out),
  .debug_control_reg_out   (debug_control_reg_out),
  .debug_cause_reg_out     (debug_cause_reg_out),
  .exc_req_out             (exc_req_out),
  .exc_vec_out             (exc_vec_out),
  .exc_fault_out           (exc_fault_out),
  .return_code_pointer_out (return_code_pointer_out),
  .gp_fault_out            (gp_fault_out)
);

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam [10:0] DN = 11'h001, BK = 11'h002, SW = 11'h004, SS = 11'h008;
  localparam [10:0] TS = 11'h010, FE = 11'h020, RD = 11'h040, WR = 11'h080;
  localparam [10:0] AW = 11'h100, CW = 11'h200, KW = 11'h400;
  reg         clk_in = 1'b0;
  reg         nrst = 1'b0;
  reg  [10:0] p = 11'h000;
  reg         prot = 1'b0, v86 = 1'b0;
  reg  [1:0]  cpl = 2'h0, io_privilege_level = 2'h0, sel = 2'h0;
  reg  [7:0]  swn = 8'h03;
  reg  [31:0] ip = 32'h0000_2000, fl = 32'h0000_0000;
  reg  [31:0] la = 32'h0000_0000, wd = 32'h0000_0000;
  wire [31:0] rd, ctl, cause, rcp, fst;
  wire        req, flt, gp;
  wire [7:0]  vec;
  integer     errors = 0, checked = 0, i;

  always #2.5 clk_in = ~clk_in;

  dbtu_trap_unit DUT
  (
    .clk_in(clk_in), .nrst_in(nrst), .instr_done_in(p[0]), .next_ip_in(ip),
    .op_break_in(p[1]), .op_swint_in(p[2]), .swint_num_in(swn),
    .prot_mode_in(prot), .v86_mode_in(v86), .cpl_in(cpl),
    .io_privilege_level_in(io_privilege_level), .processor_flags_word_in(fl),
    .ss_load_in(p[3]), .task_switch_in(p[4]), .lin_addr_in(la),
    .fetch_in(p[5]), .data_rd_in(p[6]), .data_wr_in(p[7]), .reg_sel_in(sel),
    .reg_wdata_in(wd), .bp_addr_wr_in(p[8]), .ctl_wr_in(p[9]),
    .cause_wr_in(p[10]), .bp_addr_rd_out(rd), .debug_control_reg_out(ctl),
    .debug_cause_reg_out(cause), .exc_req_out(req), .exc_vec_out(vec),
    .exc_fault_out(flt), .return_code_pointer_out(rcp), .gp_fault_out(gp),
    .fetch_start_out(fst)
  );

  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("mismatch %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask

  // one-cycle pulses; results are read at the following falling edge
  task go(input [10:0] v, input [31:0] a);
  begin
    @(negedge clk_in);
    p = v;
    la = a;
    @(negedge clk_in);
    p = 11'h000;
  end
  endtask

  task wr(input [10:0] v, input [1:0] s, input [31:0] d);
  begin
    sel = s;
    wd = d;
    go(v, la);
  end
  endtask

  // data hits must wait for the instruction to complete
  task acc(input [10:0] v, input [31:0] a, input e);
  begin
    go(v, a);
    if (!v[5])
    begin
      chk(req, 1'b0);
      go(DN, a);
    end
    chk(req, e);
  end
  endtask

  task wrap_up;
  begin
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  initial
  begin
    #20000;
    errors = errors + 1;
    wrap_up;
  end

  initial
  begin
    repeat (2) @(negedge clk_in);
    nrst = 1'b1;
    chk(ctl, 32'h0000_0000);
    chk(cause, 32'h0000_0000);
    chk(fst, 32'hFFFF_FFF0);
    acc(FE, 32'h0000_0000, 1'b0);
    go(DN | BK, la);
    chk({req, flt, gp, vec}, 11'h403);
    prot = 1'b1;
    cpl = 2'h3;
    go(DN | BK, la);
    chk({req, gp, vec}, 10'h203);
    go(DN | SW, la);
    chk(gp, 1'b1);
    prot = 1'b0;
    v86 = 1'b1;
    io_privilege_level = 2'h3;
    go(DN | SW, la);
    chk({req, gp, vec}, 10'h203);
    swn = 8'h21;
    go(DN | SW, la);
    chk({req, gp}, 2'h0);
    io_privilege_level = 2'h2;
    go(DN | SW, la);
    chk(gp, 1'b1);
    v86 = 1'b0;
    fl = 32'h0000_0100;
    ip = 32'h0000_2004;
    go(DN, la);
    chk({req, flt, vec}, 10'h201);
    chk(rcp, ip);
    chk(cause[14], 1'b1);
    go(DN | SS, la);
    chk(req, 1'b0);
    go(DN, la);
    chk(req, 1'b1);
    go(DN, la);
    chk(req, 1'b1);
    fl = 32'h0000_0000;
    wr(KW, sel, 32'h0000_0000);
    chk(cause, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1)
      wr(AW, i[1:0], 32'h0000_1000 + 32'h0000_0010 * i);
    wr(CW, sel, 32'h2F50_0399);
    chk(ctl, 32'h2F50_0399);
    for (i = 0; i < 4; i = i + 1)
    begin
      sel = i[1:0];
      @(negedge clk_in);
      chk(rd, 32'h0000_1000 + 32'h0000_0010 * i);
    end
    sel = 2'h0;
    acc(FE, 32'h0000_1000, 1'b1);
    chk(rcp, 32'h0000_1000);
    chk({flt, vec}, 9'h101);
    acc(FE, 32'h0000_1001, 1'b0);
    acc(WR, 32'h0000_1011, 1'b1);
    chk(rcp, ip);
    acc(RD, 32'h0000_1010, 1'b0);
    acc(RD, 32'h0000_1023, 1'b1);
    acc(WR, 32'h0000_1014, 1'b0);
    acc(WR, 32'h0000_1030, 1'b0);
    acc(FE, 32'h0000_1020, 1'b0);
    chk(cause[3:0], 4'h7);
    go(TS, la);
    chk(ctl, 32'h2F50_0299);
    nrst = 1'b0;
    @(negedge clk_in);
    nrst = 1'b1;
    chk(ctl, 32'h0000_0000);
    chk(cause, 32'h0000_0000);
    acc(FE, 32'h0000_1000, 1'b0);
    wr(AW, 2'h0, 32'h0000_1000);
    wr(CW, sel, 32'h0000_0002);
    acc(FE, 32'h0000_1000, 1'b1);
    wr(CW, sel, 32'h0000_0000);
    acc(FE, 32'h0000_1000, 1'b0);
    wrap_up;
  end
endmodule // tb_top
